// >>> testbench/rcpic_ctrl_sva.sv
// checker of the rcpic_ctrl port behaviour
// assumes it is bound onto rcpic_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rcpic_ctrl_sva #(
    parameter int WDOG_CYC_1 = 8,
    parameter int WDOG_CYC_2 = 16,
    parameter int WDOG_CYC_3 = 32
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire rcpic_pkg::rcpic_req_s req,
    input wire rcpic_pkg::rcpic_src_s src,
    input wire logic [1:0]            watchdog_timeout_sel,
    input wire logic [7:0]            rdata,
    input wire logic                  rvalid,
    input wire logic                  irq_req,
    input wire logic                  sys_reset
);
    import rcpic_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    AST_FORCE_RD: assert property (req.rd && req.sel == SEL_FORCE_RST |=> rvalid && rdata == FORCE_RD_VAL)
        else $error("force register read not zero");
    AST_CAUSE_B0: assert property (rvalid && $past(req.sel) == SEL_CAUSE |-> !rdata[0])
        else $error("cause bit 0 set");
    AST_ACK_RD0: assert property (rvalid && $past(req.sel) == SEL_PIN_IRQ |-> !rdata[POS_ACK])
        else $error("ack bit reads one");
    AST_IRQ: assert property (rvalid && $past(req.sel) == SEL_PIN_IRQ |->
        (rdata[POS_FLAG] & rdata[POS_INT_EN]) == $past(irq_req))
        else $error("irq request not flag and enable");
    // ------------------------------------------------------------
    // reset entry
    // ------------------------------------------------------------
    AST_FORCE: assert property (req.wr && req.from_debug && req.sel == SEL_FORCE_RST
        && req.wdata[POS_FORCE_RST] && !sys_reset |=> sys_reset)
        else $error("debug force gave no reset");
    AST_CPU_IGN: assert property (req.wr && !req.from_debug && req.sel == SEL_FORCE_RST && !sys_reset
        && src == '0 && watchdog_timeout_sel == WDOG_OFF |=> !sys_reset)
        else $error("cpu write forced a reset");
    AST_BAD_KEY: assert property (req.wr && req.sel == SEL_CAUSE && watchdog_timeout_sel != WDOG_OFF
        && !sys_reset && req.wdata != WDOG_KEY1 && req.wdata != WDOG_KEY2 |-> ##[1:2] sys_reset)
        else $error("bad key gave no reset");
    AST_SRC: assert property ((src.clock_loss || src.bad_address || src.bad_opcode) && !sys_reset
        |=> sys_reset)
        else $error("reset source ignored");
    AST_HOLD: assert property ($rose(sys_reset) |=> sys_reset [*8])
        else $error("system reset too short");
    // main scenarios seen
    cover property (rvalid && $past(req.sel) == SEL_CAUSE);
    cover property ($rose(sys_reset));
    cover property (irq_req);
endmodule
bind rcpic_ctrl rcpic_ctrl_sva #(.WDOG_CYC_1(WDOG_CYC_1), .WDOG_CYC_2(WDOG_CYC_2), .WDOG_CYC_3(WDOG_CYC_3))
    u_rcpic_ctrl_sva (.clk(clk), .rst(rst), .req(req), .src(src), .watchdog_timeout_sel(watchdog_timeout_sel),
    .rdata(rdata), .rvalid(rvalid), .irq_req(irq_req), .sys_reset(sys_reset));
`default_nettype wire

// >>> testbench/rcpic_host_model.sv
// cpu software and debug host model on the register port
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module rcpic_host_model (
    input  wire logic             clk,
    input  wire logic             rvalid,
    input  wire logic [7:0]       rdata,
    output var rcpic_pkg::rcpic_req_s req
);
    import rcpic_pkg::*;
    initial req = '0;
    // one access held across one rising edge; released lines flip
    task automatic acc(input logic r, input logic w, input logic d, input logic [1:0] s,
                       input logic [7:0] v, output logic [7:0] q);
        @(negedge clk);
        req = '{rd: r, wr: w, from_debug: d, sel: s, wdata: v};
        @(negedge clk);
        // the read answer stands from the taking edge to the next one
        q = 8'hXX;
        if (r && rvalid === 1'b1) q = rdata;
        req = '{rd: 1'b0, wr: 1'b0, from_debug: 1'b0, sel: ~s, wdata: ~v};
    endtask
    // watchdog service pair
    task automatic service();
        logic [7:0] q;
        acc(1'b0, 1'b1, 1'b0, SEL_CAUSE, WDOG_KEY1, q);
        acc(1'b0, 1'b1, 1'b0, SEL_CAUSE, WDOG_KEY2, q);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_rcpic_ctrl.sv
// self-checking bench of rcpic_ctrl with expected cause and pin values
// assumes the host model and bound checker; short watchdog counts
`timescale 1ns/1ps
`default_nettype none
module tb_rcpic_ctrl;
    import rcpic_pkg::*;
    localparam logic [8:0] STAB [10] = '{9'h180, 9'h100, 9'h040, 9'h020, 9'h010,
                                         9'h018, 9'h004, 9'h006, 9'h001, 9'h041};
    localparam logic [7:0] CTAB [10] = '{8'h02, 8'hFF, 8'h04, 8'h10, 8'h10,
                                         8'hFF, 8'h10, 8'hFF, 8'h08, 8'h0C};
    logic       clk, rst, reset_pin_n, irq_pin, irq_req, rvalid, sys_reset, pol;
    logic [1:0] wsel;
    logic [7:0] rdata, q, lfsr, bad, exp_cause;
    rcpic_src_s src;
    rcpic_req_s req;
    int         fail_count, num_checks, cyc, i;
    rcpic_ctrl #(.WDOG_CYC_1(8), .WDOG_CYC_2(16), .WDOG_CYC_3(32)) u_rcpic_ctrl (.clk(clk), .rst(rst),
        .req(req), .src(src), .reset_pin_n(reset_pin_n), .irq_pin(irq_pin), .watchdog_timeout_sel(wsel),
        .rdata(rdata), .rvalid(rvalid), .irq_req(irq_req), .sys_reset(sys_reset));
    rcpic_host_model u_rcpic_host_model (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] nxt(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] pv(input logic [4:0] lo);
        return {2'b00, pol, lo};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] exp);
        u_rcpic_host_model.acc(1'b0 + 1'b1, 1'b0, 1'b0, s, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic d, input logic [1:0] s, input logic [7:0] v);
        u_rcpic_host_model.acc(1'b0, 1'b1, d, s, v, q);
    endtask
    // waits for a reset to come and go, then reads the cause
    task automatic reset_seen(input logic [7:0] exp);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (sys_reset !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, n >= 12 && n < 40}, 8'h01);
        exp_cause = exp;
        rd(SEL_CAUSE, exp);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        rst = 1'b1; reset_pin_n = 1'b1; irq_pin = 1'b0; wsel = WDOG_OFF; src = '0;
        fail_count = 0; num_checks = 0; cyc = 0; lfsr = 8'h29; pol = 1'b0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        reset_seen(CAUSE_POR_VAL);
        rd(SEL_FORCE_RST, FORCE_RD_VAL);
        wr(1'b0, SEL_FORCE_RST, 8'h01);
        repeat (4) @(negedge clk);
        chk({7'h0, sys_reset}, 8'h00);
        rd(2'h3, 8'h00);
        // pin events in both polarities, the first picked at random
        lfsr = nxt(lfsr);
        for (int k = 0; k < 2; k++) begin
            pol = lfsr[0] ^ k[0];
            wr(1'b0, SEL_PIN_IRQ, pv(5'h02));
            irq_pin = ~pol;
            repeat (6) @(negedge clk);
            rd(SEL_PIN_IRQ, pv(5'h02));
            irq_pin = pol;
            repeat (8) @(negedge clk);
            chk({7'h0, irq_req}, 8'h01);
            rd(SEL_PIN_IRQ, pv(5'h0A));
            wr(1'b0, SEL_PIN_IRQ, pv(5'h06));
            rd(SEL_PIN_IRQ, pv(5'h02));
            wr(1'b0, SEL_PIN_IRQ, pv(5'h07));
            repeat (6) @(negedge clk);
            rd(SEL_PIN_IRQ, pv(5'h0B));
            wr(1'b0, SEL_PIN_IRQ, pv(5'h05));
            rd(SEL_PIN_IRQ, pv(5'h09));
            chk({7'h0, irq_req}, 8'h00);
            irq_pin = ~pol;
            repeat (6) @(negedge clk);
            wr(1'b0, SEL_PIN_IRQ, pv(5'h05));
            rd(SEL_PIN_IRQ, pv(5'h01));
        end
        // watchdog service, timeout, bad key, off
        wsel = 2'h1;
        for (i = 0; i < 6; i++) u_rcpic_host_model.service();
        chk({7'h0, sys_reset}, 8'h00);
        rd(SEL_CAUSE, exp_cause);
        reset_seen(8'h20);
        wsel = WDOG_OFF;
        repeat (4) @(negedge clk);
        lfsr = nxt(lfsr);
        bad = (lfsr == WDOG_KEY1 || lfsr == WDOG_KEY2) ? lfsr ^ 8'h01 : lfsr;
        wsel = 2'h1;
        wr(1'b0, SEL_CAUSE, bad);
        chk({7'h0, sys_reset}, 8'h01);
        reset_seen(8'h20);
        wsel = WDOG_OFF;
        repeat (50) @(negedge clk);
        chk({7'h0, sys_reset}, 8'h00);
        // reset sources one by one and together
        for (i = 0; i < 10; i++) begin
            @(negedge clk);
            src = rcpic_src_s'(STAB[i]);
            @(negedge clk);
            src = '0;
            if (CTAB[i] != 8'hFF) reset_seen(CTAB[i]);
            else begin
                repeat (20) @(negedge clk);
                rd(SEL_CAUSE, exp_cause);
            end
        end
        reset_pin_n = 1'b0;
        repeat (5) @(negedge clk);
        reset_pin_n = 1'b1;
        reset_seen(8'h40);
        wr(1'b0, SEL_CAUSE, WDOG_KEY2);
        rd(SEL_CAUSE, exp_cause);
        wr(1'b1, SEL_FORCE_RST, 8'h01);
        reset_seen(8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verilog/rcpic_ctrl.sv
// holds the pin interrupt control, reset-cause capture, watchdog service and forced reset
// assumes cpu and debug host share one register port on clk; rst is the power-on reset
`timescale 1ns/1ps
`default_nettype none

module rcpic_ctrl #(
    parameter int WDOG_CYC_1 = 8192,    // timeout for select 1
    parameter int WDOG_CYC_2 = 65536,   // timeout for select 2
    parameter int WDOG_CYC_3 = 262144   // timeout for select 3
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire rcpic_pkg::rcpic_req_s req,
    input  wire rcpic_pkg::rcpic_src_s src,
    input  wire logic                 reset_pin_n,
    input  wire logic                 irq_pin,
    input  wire logic [1:0]           watchdog_timeout_sel,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    output logic                      irq_req,
    output logic                      sys_reset
);
    import rcpic_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] rpin_sync_ff;
    logic [2:0] ipin_sync_ff;
    logic       rpin_low_ff;
    logic       ipin_lvl_ff;
    logic       ipin_prev_ff;

    // reset pin: three stages, idle high so no false low after power-on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpin_sync_ff <= 3'h7;
        end else begin
            rpin_sync_ff <= {rpin_sync_ff[1:0], reset_pin_n};
        end
    end

    // interrupt pin: three stages; a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ipin_sync_ff <= 3'h0;
        end else begin
            ipin_sync_ff <= {ipin_sync_ff[1:0], irq_pin};
        end
    end

    // filtered reset pin level; a one-cycle glitch never reaches the sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpin_low_ff <= 1'b0;
        end else if (rpin_sync_ff[1] == rpin_sync_ff[2]) begin
            rpin_low_ff <= ~rpin_sync_ff[2];
        end
    end

    // filtered interrupt pin level and its previous value for edge finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ipin_lvl_ff  <= 1'b0;
            ipin_prev_ff <= 1'b0;
        end else begin
            if (ipin_sync_ff[1] == ipin_sync_ff[2]) begin
                ipin_lvl_ff <= ipin_sync_ff[2];
            end
            ipin_prev_ff <= ipin_lvl_ff;
        end
    end

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    logic in_reset_ff;
    logic wr_pin;
    logic wr_cause;
    logic wr_force;

    // writes decoded per register; only the force register may be hit in reset
    assign wr_pin   = req.wr && !in_reset_ff && req.sel == SEL_PIN_IRQ;
    assign wr_cause = req.wr && !in_reset_ff && req.sel == SEL_CAUSE;
    assign wr_force = req.wr && req.from_debug && req.sel == SEL_FORCE_RST;

    // ----------------------------------------------------------------
    // pin interrupt control
    // ----------------------------------------------------------------
    logic polarity_ff;
    logic int_en_ff;
    logic mode_ff;
    logic flag_ff;
    logic pin_asserted;
    logic pin_edge;
    logic flag_set;

    // asserted level follows the polarity select
    assign pin_asserted = (ipin_lvl_ff == polarity_ff);
    assign pin_edge     = pin_asserted && (ipin_prev_ff != ipin_lvl_ff);
    assign flag_set     = pin_edge || (mode_ff && pin_asserted);

    // control bits, cleared by any system reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            polarity_ff <= 1'b0;
            int_en_ff   <= 1'b0;
            mode_ff     <= 1'b0;
        end else if (in_reset_ff) begin
            polarity_ff <= 1'b0;
            int_en_ff   <= 1'b0;
            mode_ff     <= 1'b0;
        end else if (wr_pin) begin
            polarity_ff <= req.wdata[POS_POLARITY];
            int_en_ff   <= req.wdata[POS_INT_EN];
            mode_ff     <= req.wdata[POS_MODE];
        end
    end

    // event flag; a detection in the ack cycle wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (in_reset_ff) begin
            flag_ff <= 1'b0;
        end else if (flag_set) begin
            flag_ff <= 1'b1;
        end else if (wr_pin && req.wdata[POS_ACK]) begin
            flag_ff <= 1'b0;
        end
    end

    // request follows the flag while enabled; polling otherwise
    assign irq_req = flag_ff && int_en_ff;

    // ----------------------------------------------------------------
    // watchdog timer and service sequence
    // ----------------------------------------------------------------
    logic [WDOG_CNT_W-1:0] wdog_cnt_ff;
    logic [WDOG_CNT_W-1:0] wdog_limit;
    logic                  wdog_armed_ff;
    logic                  wdog_on;
    logic                  wdog_service;
    logic                  wdog_bad_wr;
    logic                  wdog_expire;

    // a lone second key is harmless; any value but the two keys resets while enabled
    assign wdog_on      = (watchdog_timeout_sel != WDOG_OFF);
    assign wdog_service = wr_cause && wdog_armed_ff && req.wdata == WDOG_KEY2;
    assign wdog_bad_wr  = wr_cause && wdog_on
                          && req.wdata != WDOG_KEY1 && req.wdata != WDOG_KEY2;
    assign wdog_expire  = wdog_on && !in_reset_ff && (wdog_cnt_ff >= wdog_limit);

    // timeout count per select
    always_comb begin
        unique case (watchdog_timeout_sel)
            2'h1:    wdog_limit = WDOG_CNT_W'(WDOG_CYC_1 - 1);
            2'h2:    wdog_limit = WDOG_CNT_W'(WDOG_CYC_2 - 1);
            2'h3:    wdog_limit = WDOG_CNT_W'(WDOG_CYC_3 - 1);
            default: wdog_limit = '0;
        endcase
    end

    // first key arms, second key clears the timer; status left alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_armed_ff <= 1'b0;
        end else if (in_reset_ff) begin
            wdog_armed_ff <= 1'b0;
        end else if (wr_cause) begin
            wdog_armed_ff <= (req.wdata == WDOG_KEY1);
        end
    end

    // counts while enabled; cleared by service or reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_cnt_ff <= '0;
        end else if (in_reset_ff || !wdog_on || wdog_service) begin
            wdog_cnt_ff <= '0;
        end else if (!wdog_expire) begin
            wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // reset sources and sequencing
    // ----------------------------------------------------------------
    logic [7:0]           src_now;
    logic                 force_rst;
    logic                 enter;
    logic [7:0]           cause_ff;
    logic [RST_CNT_W-1:0] hold_ff;

    // active sources at this moment, by cause bit
    always_comb begin
        src_now               = 8'h00;
        src_now[POS_PIN]      = rpin_low_ff;
        src_now[POS_WDOG]     = wdog_expire || wdog_bad_wr;
        src_now[POS_OPCODE]   = src.bad_opcode
                                || (src.stop_exec && !src.stop_allow)
                                || (src.background_instr_exec && !src.background_mode_allow);
        src_now[POS_ADDRESS]  = src.bad_address;
        src_now[POS_CLK_LOSS] = src.clock_loss;
        src_now[POS_LOW_VOLT] = src.low_volt_trip && src.low_volt_rst_en;
    end

    // ----------------------------------------------------------------
    // reset-cause status
    // ----------------------------------------------------------------

    // entry needs the block out of reset, so a held source cannot restart the hold or recapture the cause while in reset
    assign force_rst = wr_force && req.wdata[POS_FORCE_RST];
    assign enter     = !in_reset_ff && (force_rst || src_now != 8'h00);

    // cause capture only at reset entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_ff <= CAUSE_POR_VAL;
        end else if (enter) begin
            cause_ff <= force_rst ? 8'h00 : src_now;
        end
    end

    // ----------------------------------------------------------------
    // system reset sequencing
    // ----------------------------------------------------------------

    // holds the system reset for the least time, longer while the reset pin stays low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_reset_ff <= 1'b1;
            hold_ff     <= RST_CNT_W'(RST_HOLD_CYC - 1);
        end else if (enter) begin
            in_reset_ff <= 1'b1;
            hold_ff     <= RST_CNT_W'(RST_HOLD_CYC - 1);
        end else if (in_reset_ff) begin
            if (hold_ff != '0) begin
                hold_ff <= hold_ff - 1'b1;
            end else if (!rpin_low_ff) begin
                in_reset_ff <= 1'b0;
            end
        end
    end

    // straight from a flip-flop so the rest of the chip sees no glitch
    assign sys_reset = in_reset_ff;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] rdata_ff;
    logic       rvalid_ff;
    logic [7:0] nxt_rdata;

    // ack bit and bit 0 of the cause register always read zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (req.sel)
            SEL_PIN_IRQ: begin
                nxt_rdata[POS_POLARITY] = polarity_ff;
                nxt_rdata[POS_FLAG]     = flag_ff;
                nxt_rdata[POS_INT_EN]   = int_en_ff;
                nxt_rdata[POS_MODE]     = mode_ff;
            end
            SEL_CAUSE:     nxt_rdata = cause_ff;
            SEL_FORCE_RST: nxt_rdata = FORCE_RD_VAL;
            default:       nxt_rdata = 8'h00;
        endcase
    end

    // one-cycle read answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req.rd;
            if (req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // read answer straight from flip-flops
    assign rdata  = rdata_ff;
    assign rvalid = rvalid_ff;
endmodule

`default_nettype wire

// >>> verilog/rcpic_pkg.sv
// holds shared constants and carrier types of the reset-cause and pin-interrupt block
// assumes one 40 MHz bus clock and a plain register port driven by cpu or debug link
package rcpic_pkg;
    // register selects on the register port
    localparam logic [1:0] SEL_PIN_IRQ   = 2'h0;  // pin_irq_status_control
    localparam logic [1:0] SEL_CAUSE     = 2'h1;  // reset_cause_status
    localparam logic [1:0] SEL_FORCE_RST = 2'h2;  // debug_force_reset_ctl
    // pin_irq_status_control fields
    localparam int POS_POLARITY = 5;
    localparam int POS_FLAG     = 3;
    localparam int POS_ACK      = 2;
    localparam int POS_INT_EN   = 1;
    localparam int POS_MODE     = 0;
    // reset_cause_status fields
    localparam int POS_POR      = 7;
    localparam int POS_PIN      = 6;
    localparam int POS_WDOG     = 5;
    localparam int POS_OPCODE   = 4;
    localparam int POS_ADDRESS  = 3;
    localparam int POS_CLK_LOSS = 2;
    localparam int POS_LOW_VOLT = 1;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h82;  // power-on plus low-voltage
    // debug_force_reset_ctl field and read value
    localparam int POS_FORCE_RST        = 0;
    localparam logic [7:0] FORCE_RD_VAL = 8'h00;
    // watchdog service sequence
    localparam logic [7:0] WDOG_KEY1 = 8'h55;
    localparam logic [7:0] WDOG_KEY2 = 8'hAA;
    localparam logic [1:0] WDOG_OFF  = 2'h0;
    // timing
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int RST_HOLD_NS     = 400;  // least time the system reset stands
    localparam int RST_HOLD_CYC    = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_CNT_W       = 5;
    localparam int WDOG_CNT_W      = 19;

    typedef struct packed {
        logic       rd;          // read strobe, one cycle
        logic       wr;          // write strobe, one cycle
        logic       from_debug;  // access made by a serial background command
        logic [1:0] sel;         // register select
        logic [7:0] wdata;
    } rcpic_req_s;

    typedef struct packed {
        logic       low_volt_trip;   // supply under trip level
        logic       low_volt_rst_en; // low_voltage_reset_enable
        logic       clock_loss;      // external clock lost
        logic       bad_opcode;      // unimplemented opcode executed
        logic       stop_exec;       // stop instruction executed
        logic       stop_allow;
        logic       background_instr_exec;       // background_instr executed
        logic       background_mode_allow;
        logic       bad_address;     // access to unimplemented address
    } rcpic_src_s;
endpackage
